//--- rtl/cprc_defines.vh
// Constants for the core clock ratio strap decoder
`ifndef CPRC_DEFINES_VH
`define CPRC_DEFINES_VH
// Clock modes
`define CPRC_MODE_PLL 2'h0
`define CPRC_MODE_BYPASS 2'h1
`define CPRC_MODE_OFF 2'h2
`define CPRC_MODE_RSVD 2'h3
// Ratio in half steps (core/bus times two)
`define CPRC_HALF_NONE 4'h0
`define CPRC_HALF_1_0 4'h2
`define CPRC_HALF_1_5 4'h3
`define CPRC_HALF_2_0 4'h4
`define CPRC_HALF_2_5 4'h5
`define CPRC_HALF_3_0 4'h6
`define CPRC_HALF_4_0 4'h8
// VCO multiplier
`define CPRC_VCO_NONE 3'h0
`define CPRC_VCO_X2 3'h2
`define CPRC_VCO_X4 3'h4
// Reset values
`define CPRC_RST_MODE `CPRC_MODE_OFF
`define CPRC_RST_CODE 4'hF
// Reset history length, matching the two synchroniser stages
`define CPRC_RST_SETTLE 2
// Reset level of single-bit controls
`define CPRC_RST_FLAG 1'h0
`endif

//--- rtl/cprc_core_pll_ratio_config.v
// Ratio strap sampler and clock mode decoder
`timescale 1ns/100ps
`include "cprc_defines.vh"
module cprc_core_pll_ratio_config (
    input wire CLK,
    input wire RESET,
    input wire [3:0] RATIO_SEL,
    input wire TEST_RESET_N,
    output reg [1:0] CLK_MODE,
    output reg [3:0] RATIO_HALF,
    output reg [2:0] VCO_MULT,
    output reg PLL_ENABLE,
    output reg CORE_CLK_RUN,
    output reg BYPASS,
    output reg CODE_RESERVED,
    output reg [3:0] CAPTURED_CODE,
    output reg TEST_RESET_FAULT
);
    // Synchronised copies of the pin inputs
    wire [3:0] sel_sync;
    wire trst_sync_n;
    // Strap code frozen at reset release
    reg [3:0] code_q;
    // Reset level history; all ones once the sync pipes hold reset-time samples
    reg [`CPRC_RST_SETTLE-1:0] rst_hist_q;
    reg settled_d;
    // Decoded clock plan for the frozen code
    reg [1:0] mode_d;
    reg [3:0] half_d;
    reg [2:0] vco_d;
    // Control levels derived from the plan
    reg pll_en_d;
    reg run_d;
    reg byp_d;
    reg rsvd_d;
    reg fault_d;

    // Ratio straps are async pins: two flops before any logic
    cprc_sync2 #(
        .WIDTH(4)
    ) u_cprc_sync2_sel (
        .clk(CLK),
        .din(RATIO_SEL),
        .dout(sel_sync)
    );

    // Test reset pin gets the same two-flop stage
    cprc_sync2 #(
        .WIDTH(1)
    ) u_cprc_sync2_trst (
        .clk(CLK),
        .din(TEST_RESET_N),
        .dout(trst_sync_n)
    );

    // Track straps throughout reset; freeze at release
    // Word crosses without gray code: safe only because straps sit still near release
    always @(posedge CLK) begin
        if (RESET) begin
            code_q <= sel_sync;
        end
    end

    // Shift in the reset level every edge
    always @(posedge CLK) begin
        rst_hist_q <= {rst_hist_q[`CPRC_RST_SETTLE-2:0], RESET};
    end

    // Pin samples taken before reset leave the pipe after the full history
    always @* begin
        settled_d = &rst_hist_q;
    end

    // Clock mode for the frozen code
    always @* begin
        mode_d = `CPRC_MODE_PLL;
        case (code_q)
            4'h3: begin
                mode_d = `CPRC_MODE_BYPASS;
            end
            4'hF: begin
                mode_d = `CPRC_MODE_OFF;
            end
            // Reserved: the board must not strap these
            4'h0, 4'h4, 4'h6, 4'h7, 4'hB, 4'hE: begin
                mode_d = `CPRC_MODE_RSVD;
            end
            // Every remaining code is a PLL ratio
            default: begin
                mode_d = `CPRC_MODE_PLL;
            end
        endcase
    end

    // Core to bus ratio and VCO multiplier for the frozen code
    always @* begin
        half_d = `CPRC_HALF_NONE;
        vco_d = `CPRC_VCO_NONE;
        case (code_q)
            // Ratios with VCO x4
            4'h1: begin
                half_d = `CPRC_HALF_1_0;
                vco_d = `CPRC_VCO_X4;
            end
            4'h2: begin
                half_d = `CPRC_HALF_2_0;
                vco_d = `CPRC_VCO_X4;
            end
            // Ratios with VCO x2
            4'h5: begin
                half_d = `CPRC_HALF_2_0;
                vco_d = `CPRC_VCO_X2;
            end
            // Three to one
            4'h8: begin
                half_d = `CPRC_HALF_3_0;
                vco_d = `CPRC_VCO_X2;
            end
            // Half step 1.5 puts core edges between bus edges; code A is four to one
            4'h9: begin
                half_d = `CPRC_HALF_1_5;
                vco_d = `CPRC_VCO_X2;
            end
            4'hA: begin
                half_d = `CPRC_HALF_4_0;
                vco_d = `CPRC_VCO_X2;
            end
            // Another half step
            4'hC: begin
                half_d = `CPRC_HALF_2_5;
                vco_d = `CPRC_VCO_X2;
            end
            // Unity ratio through the x2 VCO
            4'hD: begin
                half_d = `CPRC_HALF_1_0;
                vco_d = `CPRC_VCO_X2;
            end
            // Bypass runs the core straight off the reference at 1:1
            4'h3: begin
                half_d = `CPRC_HALF_1_0;
            end
            // Off and reserved codes carry no ratio and no VCO setting
            default: begin
                half_d = `CPRC_HALF_NONE;
                vco_d = `CPRC_VCO_NONE;
            end
        endcase
    end

    // Control levels follow the decoded mode
    always @* begin
        pll_en_d = (mode_d == `CPRC_MODE_PLL);
        byp_d = (mode_d == `CPRC_MODE_BYPASS);
        // Reserved codes get no clock: safest choice for an undefined mode
        run_d = pll_en_d || byp_d;
        rsvd_d = (mode_d == `CPRC_MODE_RSVD);
        // Judged only once the sync pipe holds reset-time samples
        fault_d = RESET && settled_d && trst_sync_n;
    end

    // Clock plan outputs held at clock off in reset, since straps are not final
    always @(posedge CLK) begin
        if (RESET) begin
            CLK_MODE <= `CPRC_RST_MODE;
            RATIO_HALF <= `CPRC_HALF_NONE;
            VCO_MULT <= `CPRC_VCO_NONE;
        end else begin
            CLK_MODE <= mode_d;
            RATIO_HALF <= half_d;
            VCO_MULT <= vco_d;
        end
    end

    // PLL enable and core clock gate
    always @(posedge CLK) begin
        if (RESET) begin
            PLL_ENABLE <= `CPRC_RST_FLAG;
            CORE_CLK_RUN <= `CPRC_RST_FLAG;
            BYPASS <= `CPRC_RST_FLAG;
        end else begin
            PLL_ENABLE <= pll_en_d;
            CORE_CLK_RUN <= run_d;
            BYPASS <= byp_d;
        end
    end

    // Status of the captured strap
    always @(posedge CLK) begin
        if (RESET) begin
            CODE_RESERVED <= `CPRC_RST_FLAG;
            CAPTURED_CODE <= `CPRC_RST_CODE;
        end else begin
            CODE_RESERVED <= rsvd_d;
            CAPTURED_CODE <= code_q;
        end
    end

    // Test reset left released in reset: level while in reset, low after release
    always @(posedge CLK) begin
        TEST_RESET_FAULT <= fault_d;
    end
endmodule // cprc_core_pll_ratio_config

// Two-flop synchroniser for quasi-static pin inputs
module cprc_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    // Only the second stage is read; the first may go metastable
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // No reset: the pipe refills from the pin within two edges anyway
    always @(posedge clk) begin
        meta_q <= din;
        sync_q <= meta_q;
    end

    // Second stage drives the output
    assign dout = sync_q;
endmodule // cprc_sync2

//--- verif/cprc_strap_model.sv
// Board strap and test reset source for the ratio decoder
`timescale 1ns/100ps
module cprc_strap_model (
    input wire logic [3:0] code_in,
    input wire logic hard_reset,
    input wire logic trst_float,
    output wire logic [3:0] ratio_sel,
    output wire logic test_reset_n
);
    // Test reset tied to hard reset, so it can never lag the device reset
    // Left floating, the pin's pull-up shows it released
    assign test_reset_n = trst_float ? 1'b1 : ~hard_reset;
    // Straps pass through; reserved codes only when the bench asks
    assign ratio_sel = code_in;
endmodule // cprc_strap_model

//--- verif/cprc_core_pll_ratio_config_asserts.sv
// Checker for the ratio strap decoder
`timescale 1ns/100ps
module cprc_core_pll_ratio_config_asserts (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [3:0] CAPTURED_CODE,
    input wire logic [1:0] CLK_MODE,
    input wire logic [3:0] RATIO_HALF,
    input wire logic [2:0] VCO_MULT,
    input wire logic CORE_CLK_RUN,
    input wire logic BYPASS,
    input wire logic CODE_RESERVED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    chk_bypass_one: assert property (BYPASS |-> CAPTURED_CODE == 4'h3 && RATIO_HALF == 4'h2)
        else $error("bypass decode wrong");
    chk_off_stop: assert property (CAPTURED_CODE == 4'hF |-> !CORE_CLK_RUN && CLK_MODE == 2'h2)
        else $error("clock off decode wrong");
    chk_rsvd_none: assert property (CODE_RESERVED |-> CLK_MODE == 2'h3 && !CORE_CLK_RUN)
        else $error("reserved code got a mode");
    chk_vco_four: assert property (VCO_MULT == 3'h4 |-> RATIO_HALF == {1'b0, CAPTURED_CODE[1:0], 1'b0})
        else $error("x4 ratio wrong");
    chk_half_step: assert property (CAPTURED_CODE == 4'h9 |-> RATIO_HALF == 4'h3)
        else $error("1.5 ratio wrong");
    chk_code_hold: assert property (!$past(RESET) |=> $stable(CAPTURED_CODE))
        else $error("captured code moved");
    // Main scenarios reached
    cover property (BYPASS);
    cover property (CODE_RESERVED);
    cover property (CLK_MODE == 2'h0 && VCO_MULT == 3'h2);
endmodule // cprc_core_pll_ratio_config_asserts
bind cprc_core_pll_ratio_config cprc_core_pll_ratio_config_asserts u_chk (.CLK(CLK),
    .RESET(RESET), .CAPTURED_CODE(CAPTURED_CODE), .CLK_MODE(CLK_MODE), .RATIO_HALF(RATIO_HALF),
    .VCO_MULT(VCO_MULT), .CORE_CLK_RUN(CORE_CLK_RUN), .BYPASS(BYPASS), .CODE_RESERVED(CODE_RESERVED));

//--- verif/cprc_core_pll_ratio_config_tb_top.sv
// Testbench for the ratio strap decoder
`timescale 1ns/100ps
module cprc_core_pll_ratio_config_tb_top;
    reg clk = 0;
    reg reset = 1;
    reg [3:0] code = 4'h3;
    reg trst_float = 1'b0;
    wire [3:0] sel, cap, half;
    wire [2:0] vco;
    wire [1:0] mode;
    wire trst_n, pll_en, run, byp, rsvd, flt;
    int miscompares = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    cprc_strap_model u_cprc_strap_model (.code_in(code), .hard_reset(reset), .ratio_sel(sel),
        .trst_float(trst_float), .test_reset_n(trst_n));
    cprc_core_pll_ratio_config u_cprc_core_pll_ratio_config (.CLK(clk), .RESET(reset),
        .RATIO_SEL(sel), .TEST_RESET_N(trst_n), .CLK_MODE(mode), .RATIO_HALF(half),
        .VCO_MULT(vco), .PLL_ENABLE(pll_en), .CORE_CLK_RUN(run), .BYPASS(byp),
        .CODE_RESERVED(rsvd), .CAPTURED_CODE(cap), .TEST_RESET_FAULT(flt));
    task chk(input string nm, input [3:0] exp, input [3:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Reset with a strap, then move the strap to prove it is ignored
    task boot(input [3:0] c);
        @(negedge clk);
        reset = 1;
        code = c;
        repeat (10) @(negedge clk);
        chk("rfault", {3'h0, trst_float}, {3'h0, flt});
        reset = 0;
        repeat (2) @(negedge clk);
        code = ~c;
        repeat (3) @(negedge clk);
        chk("code", c, cap);
        chk("fault", 4'h0, {3'h0, flt});
    endtask
    task test_ratio(input [31:0] cs, input [31:0] hs);
        for (int i = 0; i < 8; i++) begin
            boot(cs[28-4*i +: 4]);
            chk("half", hs[28-4*i +: 4], half);
            chk("vco", (i < 2) ? 4'h4 : 4'h2, {1'h0, vco});
            chk("mode", 4'hC, {pll_en, run, mode});
        end
        $display("test_ratio done");
    endtask
    task test_special;
        boot(4'h3);
        chk("bypass", 4'h9, {byp, pll_en, mode});
        chk("bhalf", 4'h2, half);
        chk("bvco", 4'h0, {1'h0, vco});
        boot(4'hF);
        chk("off", 4'h2, {run, byp, mode});
        chk("ohalf", 4'h0, half);
        $display("test_special done");
    endtask
    task test_reserved(input [23:0] cs);
        for (int i = 0; i < 6; i++) begin
            boot(cs[20-4*i +: 4]);
            chk("rsvd", 4'hB, {rsvd, run, mode});
            chk("rhalf", 4'h0, half);
        end
        $display("test_reserved done");
    endtask
    // Test reset left floating: fault shows in reset, mode still decodes
    task test_trst_loose;
        trst_float = 1'b1;
        boot(4'h8);
        chk("lmode", 4'hC, {pll_en, run, mode});
        trst_float = 1'b0;
        $display("test_trst_loose done");
    endtask
    task complete_run;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        test_ratio(32'h12589ACD, 32'h24463852);
        test_special;
        test_reserved(24'h0467BE);
        test_trst_loose;
        complete_run;
    end
endmodule // cprc_core_pll_ratio_config_tb_top
